//--- rtl/sea_pkg.sv
package sea_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] SEA_OFS_ACCESS    = 8'hBC;
	localparam logic [7:0] SEA_OFS_IRQ_STAT  = 8'hD0;
	localparam logic [7:0] SEA_OFS_IRQ_MASK  = 8'hD4;

	// ----------------------------------------
	// access word layout and reset
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] data;
		logic [6:0]  addr;
		logic        rsvd;
		logic [1:0]  rate;
		logic        al_dis;
		logic        al_status;
		logic        al_success;
		logic        err;
		logic        cmd;
		logic        start;
	} sea_access_t;

	localparam sea_access_t SEA_ACCESS_RST = 32'h0000_0060;

	// ----------------------------------------
	// clock rates
	// ----------------------------------------
	localparam logic [1:0] SEA_RATE_TEST  = 2'h3;
	localparam int         SEA_DIV_NORMAL = 1024;
	localparam int         SEA_DIV_TEST   = 4;
	localparam int         SEA_PHASES     = 4;

	// ----------------------------------------
	// events and autoload
	// ----------------------------------------
	localparam int         SEA_EV_W    = 3;
	localparam int         SEA_EV_DONE = 0;
	localparam int         SEA_EV_ERR  = 1;
	localparam int         SEA_EV_AL   = 2;
	localparam logic [6:0] SEA_AL_BASE = 7'h00;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} sea_bus_t;

	typedef enum logic [2:0] {SEA_IDLE, SEA_START, SEA_BYTE, SEA_ACK, SEA_STOP} sea_state_t;

endpackage

//--- rtl/sea_eeprom_port.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module sea_eeprom_port #(
	parameter int CLK_DIV = sea_pkg::SEA_DIV_NORMAL
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             arst_n,
	// register port
	input  wire sea_pkg::sea_bus_t bus,
	output logic [31:0]           rdata,
	output logic                  irq,
	// memory pins
	output logic                  ee_scl,
	input  wire logic             ee_sda_in,
	output logic                  ee_sda_out,
	output logic                  ee_sda_oe,
	// fundamental reset pin and autoload targets
	input  wire logic             fundamental_reset_input_n,
	output logic [15:0]           subsystem_vendor_ident,
	output logic [15:0]           subsystem_device_ident
);
	import sea_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic sda_m_q, sda_s_q, fr_m_q, fr_s_q, fr_prev_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sda_m_q   <= 1'b1;
			sda_s_q   <= 1'b1;
			// idle level of the pin, so no false release edge follows reset
			fr_m_q    <= 1'b1;
			fr_s_q    <= 1'b1;
			fr_prev_q <= 1'b1;
		end else begin
			sda_m_q   <= ee_sda_in;
			sda_s_q   <= sda_m_q;
			fr_m_q    <= fundamental_reset_input_n;
			fr_s_q    <= fr_m_q;
			fr_prev_q <= fr_s_q;
		end
	end

	// ----------------------------------------
	// state declarations
	// ----------------------------------------
	sea_state_t  st_q, st_d;
	logic [1:0]  ph_q, ph_d, byte_q, byte_d;
	logic [2:0]  bit_q, bit_d;
	logic [7:0]  sh_q, sh_d;
	logic [15:0] rx_q, rx_d;
	logic        nak_q, nak_d, auto_q, auto_d, rd_q, rd_d;
	logic        scl_q, scl_d, pull_q, pull_d, fin;
	logic [11:0] cnt_q, cnt_d, qlim;
	logic        busy, tick;
	sea_access_t ctrl_q, ctrl_d;
	logic        al_pend_q, al_pend_d, al_idx_q, al_idx_d;
	logic [15:0] svid_q, svid_d, sdid_q, sdid_d;
	logic [SEA_EV_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic [31:0] rdata_q, rdata_d;
	logic        irq_q, irq_d;

	// ----------------------------------------
	// memory clock divider
	// ----------------------------------------
	// reserved rate codes fall back to the normal divide
	always_comb begin
		busy  = (st_q != SEA_IDLE);
		qlim  = (ctrl_q.rate == SEA_RATE_TEST)
			? 12'(SEA_DIV_TEST / SEA_PHASES - 1)
			: 12'(CLK_DIV / SEA_PHASES - 1);
		tick  = busy && (cnt_q == qlim);
		cnt_d = (!busy || tick) ? 12'h000 : cnt_q + 12'h001;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			cnt_q <= 12'h000;
		else
			cnt_q <= cnt_d;
	end

	// ----------------------------------------
	// serial engine
	// ----------------------------------------
	// each bit spans four quarter phases; scl high in the middle two
	always_comb begin
		st_d   = st_q;
		ph_d   = ph_q;
		bit_d  = bit_q;
		byte_d = byte_q;
		sh_d   = sh_q;
		rx_d   = rx_q;
		nak_d  = nak_q;
		auto_d = auto_q;
		rd_d   = rd_q;
		fin    = 1'b0;
		case (st_q)
			SEA_IDLE: begin
				if (al_pend_q || ctrl_q.start) begin
					st_d   = SEA_START;
					ph_d   = 2'h0;
					nak_d  = 1'b0;
					auto_d = al_pend_q;
					rd_d   = al_pend_q | ~ctrl_q.cmd;
					sh_d   = al_pend_q ? {SEA_AL_BASE + {6'h00, al_idx_q}, 1'b1}
						: {ctrl_q.addr, ~ctrl_q.cmd};
				end
			end
			default: begin
				if (tick) begin
					ph_d = ph_q + 2'h1;
					if (ph_q == 2'h2) begin
						if (st_q == SEA_BYTE && rd_q && byte_q != 2'h0)
							sh_d = {sh_q[6:0], sda_s_q};
						if (st_q == SEA_ACK && (byte_q == 2'h0 || !rd_q) && sda_s_q)
							nak_d = 1'b1;
					end
					if (ph_q == 2'h3) begin
						case (st_q)
							SEA_START: begin
								st_d   = SEA_BYTE;
								bit_d  = 3'h0;
								byte_d = 2'h0;
							end
							SEA_BYTE: begin
								if (bit_q == 3'h7) begin
									st_d = SEA_ACK;
									if (rd_q && byte_q != 2'h0)
										rx_d = {rx_q[7:0], sh_q};
								end else begin
									bit_d = bit_q + 3'h1;
									if (!(rd_q && byte_q != 2'h0))
										sh_d = {sh_q[6:0], 1'b1};
								end
							end
							SEA_ACK: begin
								bit_d = 3'h0;
								// a missing acknowledge aborts the frame at once
								if (nak_q || byte_q == 2'h2) begin
									st_d = SEA_STOP;
								end else begin
									byte_d = byte_q + 2'h1;
									st_d   = SEA_BYTE;
									sh_d   = rd_q ? 8'hFF : (byte_q == 2'h0 ?
										ctrl_q.data[15:8] : ctrl_q.data[7:0]);
								end
							end
							default: begin
								st_d = SEA_IDLE;
								fin  = 1'b1;
							end
						endcase
					end
				end
			end
		endcase
		case (st_q)
			SEA_START: begin
				scl_d  = (ph_q != 2'h3);
				pull_d = ph_q[1];
			end
			SEA_BYTE: begin
				scl_d  = ph_q[0] ^ ph_q[1];
				pull_d = !(rd_q && byte_q != 2'h0) && !sh_q[7];
			end
			SEA_ACK: begin
				scl_d  = ph_q[0] ^ ph_q[1];
				pull_d = rd_q && byte_q == 2'h1;
			end
			SEA_STOP: begin
				scl_d  = (ph_q != 2'h0);
				pull_d = ~ph_q[1];
			end
			default: begin
				scl_d  = 1'b1;
				pull_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_q   <= SEA_IDLE;
			ph_q   <= 2'h0;
			bit_q  <= 3'h0;
			byte_q <= 2'h0;
			sh_q   <= 8'hFF;
			rx_q   <= 16'h0000;
			nak_q  <= 1'b0;
			auto_q <= 1'b0;
			rd_q   <= 1'b0;
			scl_q  <= 1'b1;
			pull_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			ph_q   <= ph_d;
			bit_q  <= bit_d;
			byte_q <= byte_d;
			sh_q   <= sh_d;
			rx_q   <= rx_d;
			nak_q  <= nak_d;
			auto_q <= auto_d;
			rd_q   <= rd_d;
			scl_q  <= scl_d;
			pull_q <= pull_d;
		end
	end

	// ----------------------------------------
	// registers, autoload and interrupt
	// ----------------------------------------
	always_comb begin
		ctrl_d    = ctrl_q;
		al_pend_d = al_pend_q;
		al_idx_d  = al_idx_q;
		svid_d    = svid_q;
		sdid_d    = sdid_q;
		mask_d    = mask_q;
		ev        = '0;
		// the word is locked while a cycle is pending to keep its fields stable
		if (bus.wr && bus.addr == SEA_OFS_ACCESS && !busy && !ctrl_q.start
			&& !al_pend_q) begin
			ctrl_d.start  = bus.wdata[0];
			ctrl_d.cmd    = bus.wdata[1];
			ctrl_d.al_dis = bus.wdata[5];
			ctrl_d.rate   = bus.wdata[7:6];
			ctrl_d.addr   = bus.wdata[15:9];
			ctrl_d.data   = bus.wdata[31:16];
		end
		if (bus.wr && bus.addr == SEA_OFS_IRQ_MASK)
			mask_d = bus.wdata[SEA_EV_W-1:0];
		if (bus.rd && bus.addr == SEA_OFS_ACCESS)
			ctrl_d.al_success = 1'b0;
		if (fr_s_q && !fr_prev_q && !ctrl_q.al_dis) begin
			al_pend_d          = 1'b1;
			al_idx_d           = 1'b0;
			ctrl_d.al_status   = 1'b0;
			ctrl_d.al_success  = 1'b0;
		end
		if (fin) begin
			if (auto_q) begin
				if (nak_q) begin
					al_pend_d        = 1'b0;
					ctrl_d.al_status = 1'b0;
					ev[SEA_EV_AL]    = 1'b1;
				end else begin
					if (al_idx_q)
						sdid_d = rx_q;
					else
						svid_d = rx_q;
					al_idx_d = 1'b1;
					if (al_idx_q) begin
						al_pend_d         = 1'b0;
						ctrl_d.al_status  = 1'b1;
						ctrl_d.al_success = 1'b1;
						ev[SEA_EV_AL]     = 1'b1;
					end
				end
			end else begin
				ctrl_d.start = 1'b0;
				ctrl_d.err   = nak_q;
				if (rd_q && !nak_q)
					ctrl_d.data = rx_q;
				ev[SEA_EV_DONE] = 1'b1;
				ev[SEA_EV_ERR]  = nak_q;
			end
		end
		// a new event wins over a clear in the same cycle
		stat_d = stat_q;
		if (bus.wr && bus.addr == SEA_OFS_IRQ_STAT)
			stat_d = stat_q & ~bus.wdata[SEA_EV_W-1:0];
		stat_d = stat_d | ev;
		irq_d  = |(stat_d & mask_d);
		case (bus.addr)
			SEA_OFS_ACCESS:   rdata_d = ctrl_q;
			SEA_OFS_IRQ_STAT: rdata_d = {29'h0000_0000, stat_q};
			SEA_OFS_IRQ_MASK: rdata_d = {29'h0000_0000, mask_q};
			default:          rdata_d = 32'h0000_0000;
		endcase
		if (!bus.rd)
			rdata_d = 32'h0000_0000;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q    <= SEA_ACCESS_RST;
			al_pend_q <= 1'b0;
			al_idx_q  <= 1'b0;
			svid_q    <= 16'h0000;
			sdid_q    <= 16'h0000;
			stat_q    <= '0;
			mask_q    <= '0;
			rdata_q   <= 32'h0000_0000;
			irq_q     <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			al_pend_q <= al_pend_d;
			al_idx_q  <= al_idx_d;
			svid_q    <= svid_d;
			sdid_q    <= sdid_d;
			stat_q    <= stat_d;
			mask_q    <= mask_d;
			rdata_q   <= rdata_d;
			irq_q     <= irq_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// open drain: the data line is only ever pulled low
	logic sda0_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			sda0_q <= 1'b0;
		else
			sda0_q <= 1'b0;
	end

	assign rdata                  = rdata_q;
	assign irq                    = irq_q;
	assign ee_scl                 = scl_q;
	assign ee_sda_out             = sda0_q;
	assign ee_sda_oe              = pull_q;
	assign subsystem_vendor_ident = svid_q;
	assign subsystem_device_ident = sdid_q;

endmodule // sea_eeprom_port

//--- bench/sea_port_assertions.sv
`timescale 1ns/100ps
module sea_port_checker import sea_pkg::*; #(
	parameter int CLK_DIV = 16
) (
	// watched ports
	input wire logic        clock,
	input wire logic        arst_n,
	input wire sea_bus_t    bus,
	input wire logic [31:0] rdata,
	input wire logic        irq,
	input wire logic        ee_scl,
	input wire logic        ee_sda_out,
	input wire logic        ee_sda_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [15:0] held_q;
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n) held_q <= 16'h0;
		else held_q <= $changed(ee_scl) ? 16'h0 : held_q + 16'h1;
	a_rdata_quiet: assert property (!$past(bus.rd) |-> rdata == 32'h0)
		else $error("read data not zero outside a read reply");
	a_rsvd_zero: assert property ($past(bus.rd) && $past(bus.addr) == SEA_OFS_ACCESS |-> !rdata[8])
		else $error("reserved bit 8 reads one");
	a_success_rdclr: assert property ($past(bus.rd, 2) && $past(bus.addr, 2) == SEA_OFS_ACCESS
		&& $past(bus.rd) && $past(bus.addr) == SEA_OFS_ACCESS |-> !rdata[3])
		else $error("autoload success bit survived a read");
	a_open_drain: assert property (ee_sda_out == 1'b0)
		else $error("data line driven high");
	a_scl_quarter: assert property ($changed(ee_scl) |-> held_q >= 16'(CLK_DIV / 4 - 1))
		else $error("serial clock phase shorter than a quarter period");
	a_sda_scl_apart: assert property ($changed(ee_sda_oe) |-> $stable(ee_scl))
		else $error("data and clock lines moved together");
	a_mask_quiet: assert property (bus.wr && bus.addr == SEA_OFS_IRQ_MASK && bus.wdata[2:0] == 3'h0
		|-> ##2 !irq)
		else $error("interrupt high with every source masked");
	a_field_readback: assert property (bus.wr && bus.addr == SEA_OFS_ACCESS && !bus.wdata[0] && ee_scl
		##1 bus.rd && bus.addr == SEA_OFS_ACCESS |=> rdata[15:9] == $past(bus.wdata[15:9], 2)
		&& rdata[1] == $past(bus.wdata[1], 2))
		else $error("address or command field lost");
endmodule // sea_port_checker

bind sea_eeprom_port sea_port_checker #(.CLK_DIV(CLK_DIV)) sea_port_checker_inst (.clock(clock),
	.arst_n(arst_n), .bus(bus), .rdata(rdata), .irq(irq), .ee_scl(ee_scl),
	.ee_sda_out(ee_sda_out), .ee_sda_oe(ee_sda_oe));

//--- bench/sea_mem_model.sv
`timescale 1ns/100ps
module sea_mem_model #(
	parameter logic [15:0] M0 = 16'h0,
	parameter logic [15:0] M1 = 16'h0
) (
	// two-wire side
	input  wire logic scl,
	input  wire logic sda,
	// forced refusal of every acknowledge
	input  wire logic nak,
	output logic      pull
);
	logic [15:0] mem [0:127];
	logic [7:0]  sh;
	logic [6:0]  a;
	logic        rd = 1'b0;
	int          bn = 0;
	int          byn = 0;
	initial begin
		mem[0] = M0;
		mem[1] = M1;
		pull = 1'b0;
	end
	// frame start: data falls while clock high
	always @(negedge sda)
		if (scl === 1'b1) begin
			bn = 0;
			byn = 0;
			rd = 1'b0;
		end
	always @(posedge scl) begin
		if (bn < 8) sh = {sh[6:0], sda};
		else if (byn == 0) {a, rd} = sh;
		else if (!rd && byn < 3) mem[a][((byn == 1) ? 15 : 7) -: 8] = sh;
		bn = (bn == 8) ? 0 : bn + 1;
		if (bn == 0) byn++;
	end
	// change only while clock low; released line floats to the pull-up
	always @(negedge scl)
		if (bn == 8) pull <= !nak && !(rd && byn > 0);
		else pull <= !nak && rd && byn inside {[1:2]} && !mem[a][((byn == 1) ? 15 : 7) - bn];
endmodule // sea_mem_model

//--- bench/sea_eeprom_port_test.sv
`timescale 1ns/100ps
module sea_eeprom_port_test;
	import sea_pkg::*;
	localparam logic [15:0] W0 = 16'h1E2D;
	localparam logic [15:0] W1 = 16'h3C4B;
	logic        clock = 1'b0;
	logic        arst_n = 1'b0;
	logic        frst_n = 1'b1;
	logic        nak = 1'b0;
	logic        irq, scl, sda_oe, pull, p1_q;
	sea_bus_t    bus = '0;
	logic [31:0] rdata, seed = 32'hC14D;
	logic [15:0] vid, did;
	logic [63:0] e;
	logic [63:0] q[$];
	logic [6:0]  a;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	wire         sda = ~(sda_oe | pull);
	always #5 clock = ~clock;
	sea_eeprom_port #(.CLK_DIV(16)) sea_eeprom_port_inst (
		.clock(clock), .arst_n(arst_n), .bus(bus), .rdata(rdata), .irq(irq), .ee_scl(scl),
		.ee_sda_in(sda), .ee_sda_out(), .ee_sda_oe(sda_oe), .fundamental_reset_input_n(frst_n),
		.subsystem_vendor_ident(vid), .subsystem_device_ident(did));
	sea_mem_model #(.M0(W0), .M1(W1)) sea_mem_model_inst (
		.scl(scl), .sda(sda), .nak(nak), .pull(pull));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] g, x);
		n_tests++;
		if (g !== x) begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic op(input logic w, r, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge clock);
		bus <= '{addr: ad, wdata: wd, wr: w, rd: r};
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] x, m);
		q.push_back({m, x & m});
		op(1'b0, 1'b1, ad, 32'h0);
	endtask
	task automatic idle(input int n);
		op(1'b0, 1'b0, 8'h0, 32'h0);
		repeat (n) @(posedge clock);
	endtask
	// bounded so a dead engine ends the run instead of hanging it
	task automatic wait_irq();
		idle(0);
		for (int i = 0; i < 3000 && irq !== 1'b1; i++)
			@(posedge clock);
		chk({31'h0, irq}, 32'h1);
		op(1'b1, 1'b0, SEA_OFS_IRQ_STAT, 32'h7);
	endtask
	task automatic reboot();
		idle(0);
		frst_n <= 1'b0;
		repeat (4) @(posedge clock);
		frst_n <= 1'b1;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clock) begin
		p1_q <= bus.rd;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end
	always @(negedge clock)
		if (p1_q === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			chk(rdata & e[63:32], e[31:0]);
		end
	initial begin
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		reboot();
		idle(600);
		chk({vid, did}, 32'h0);
		rd(SEA_OFS_ACCESS, 32'h60, '1);
		rd(8'h40, 32'h0, '1);
		op(1'b1, 1'b0, SEA_OFS_IRQ_STAT, 32'h7);
		op(1'b1, 1'b0, SEA_OFS_IRQ_MASK, 32'h7);
		rd(SEA_OFS_IRQ_MASK, 32'h7, '1);
		$display("test reset done");
		op(1'b1, 1'b0, SEA_OFS_ACCESS, 32'h40);
		reboot();
		wait_irq();
		chk({vid, did}, {W0, W1});
		rd(SEA_OFS_ACCESS, 32'h18, 32'h18);
		rd(SEA_OFS_ACCESS, 32'h10, 32'h18);
		rd(SEA_OFS_IRQ_STAT, 32'h0, 32'h7);
		$display("test autoload done");
		for (int k = 0; k < 2; k++) begin
			seed = lfsr(seed);
			a = seed[22:16];
			op(1'b1, 1'b0, SEA_OFS_ACCESS, {seed[15:0], a, 9'h063});
			wait_irq();
			chk({16'h0, sea_mem_model_inst.mem[a]}, {16'h0, seed[15:0]});
			rd(SEA_OFS_ACCESS, {seed[15:0], a, 9'h072}, '1);
			op(1'b1, 1'b0, SEA_OFS_ACCESS, {~seed[15:0], a, 9'h061});
			wait_irq();
			rd(SEA_OFS_ACCESS, {seed[15:0], a, 9'h070}, '1);
		end
		$display("test access done");
		nak <= 1'b1;
		op(1'b1, 1'b0, SEA_OFS_ACCESS, {16'h0, a, 9'h061});
		wait_irq();
		nak <= 1'b0;
		rd(SEA_OFS_ACCESS, 32'h4, 32'h7);
		op(1'b1, 1'b0, SEA_OFS_ACCESS, 32'h3C0);
		rd(SEA_OFS_ACCESS, 32'h2C0, 32'hFFE3);
		op(1'b1, 1'b0, SEA_OFS_IRQ_MASK, 32'h0);
		idle(4);
		$display("test fields done");
		close_out();
	end
endmodule // sea_eeprom_port_test
